// >>> rtl_pkg.sv
// Package for the remote temperature limit and alarm block.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
package rtl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ALARM_STATUS      = 8'h02;
	localparam logic [7:0] ADDR_LOW_LIMIT_HIGH    = 8'h08;
	localparam logic [7:0] ADDR_LOW_LIMIT_HIGH_B  = 8'h0E;
	localparam logic [7:0] ADDR_LOW_LIMIT_LOW     = 8'h14;
	localparam logic [7:0] ADDR_CRIT_LIMIT        = 8'h19;
	localparam logic [7:0] ADDR_CRIT_HYST         = 8'h21;
	localparam logic [7:0] ADDR_FILT_CMP_CFG      = 8'hBF;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_LOW_LIMIT_HIGH     = 8'h00;
	localparam logic [2:0] RST_LOW_LIMIT_FRAC     = 3'h0;
	localparam logic [7:0] RST_CRIT_LIMIT         = 8'h55;
	localparam logic [7:0] RST_CRIT_HYST          = 8'h0A;
	localparam logic [2:0] RST_FILT_CMP_CFG       = 3'h0;
	localparam logic [7:0] RST_STATUS             = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LOW_FRAC_MSB   = 7;
	localparam int LOW_FRAC_LSB   = 5;
	localparam int CFG_FILT_MSB   = 2;
	localparam int CFG_FILT_LSB   = 1;
	localparam int CFG_CMP_BIT    = 0;
	localparam int ST_BUSY_BIT    = 7;
	localparam int ST_LOCAL_HIGH  = 6;
	localparam int ST_REMOTE_LOW  = 3;
	localparam int ST_REMOTE_CRIT = 1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RTL_FILT_OFF  = 3'b001,
		RTL_FILT_MIN  = 3'b010,
		RTL_FILT_MAX  = 3'b100
	} rtl_filter_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtl_req_s;

	typedef struct packed {
		logic [10:0] remote_temp;
		logic [7:0]  local_temp;
		logic [7:0]  local_high_limit;
		logic        busy;
	} rtl_meas_s;

endpackage

// >>> rtl_limit_alarms.sv
// Remote temperature limit checking and latched alarm status.
// Assumes the serial bus front end presents register accesses as
// one-cycle strobes on i_reg_req, and the converter presents its
// readings and busy flag on the core clock.
//
// Notes on behaviour
// - Remote low setpoint high byte is read/write at 08 and 0E, resets to 0, signed.
// - Remote low setpoint low byte keeps bits 7:5 and reads 0 in bits 4:0, resets to 0.
// - Remote critical limit is an 8-bit integer register resetting to 85.
// - Critical limit takes one write after reset, only while unlock is set, then locks.
// - Critical condition holds until remote falls below limit minus hysteresis (at 21).
// - Filter field bits 2:1 of BF: 00 off, 01 and 10 minimal, 11 maximum.
// - Comparator bit 0 makes the alert follow the live conditions; else it is latched.
// - Alarm bits at 02 latch until read and clear only if the condition has gone.
// - Status bit 7 shows converter busy and never drives the alert.
// - Status bit 6 flags local temperature above the local high setpoint.
// - Status bit 3 flags remote temperature below the remote low setpoint.
// - Status bit 1 flags remote temperature above the critical limit.
`timescale 1ns/1ns
module rtl_limit_alarms (
	input  wire logic                 i_core_clk,       // Core clock, 100 MHz
	input  wire logic                 i_reset,          // Synchronous reset, high
	input  wire rtl_pkg::rtl_req_s    i_reg_req,        // Register access strobes
	input  wire rtl_pkg::rtl_meas_s   i_meas,           // Converter results
	input  wire logic                 i_crit_unlock,    // Critical limit unlock bit
	output logic [7:0]                o_reg_rdata,      // Read data, one cycle later
	output logic                      o_reg_rvalid,     // Read data valid pulse
	output logic                      o_alert,          // Alert asserted, high
	output rtl_pkg::rtl_filter_e      o_filter_level,   // Selected filter level
	output logic                      o_crit_active     // Critical condition active
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Integer degrees to signed eighths of a degree
	function automatic logic signed [12:0] deg_to_eighths(input logic signed [8:0] deg);
		deg_to_eighths = {deg[8], deg, 3'b000};
	endfunction

	function automatic rtl_pkg::rtl_filter_e decode_filter(input logic [1:0] code);
		rtl_pkg::rtl_filter_e f;
		f = rtl_pkg::RTL_FILT_OFF;
		case (code)
			2'h0: f = rtl_pkg::RTL_FILT_OFF;
			2'h1: f = rtl_pkg::RTL_FILT_MIN;
			2'h2: f = rtl_pkg::RTL_FILT_MIN;
			default: f = rtl_pkg::RTL_FILT_MAX;
		endcase
		return f;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]           low_high_q,   low_high_d;
	logic [2:0]           low_frac_q,   low_frac_d;
	logic [7:0]           crit_limit_q, crit_limit_d;
	logic                 crit_locked_q, crit_locked_d;
	logic [7:0]           crit_hyst_q,  crit_hyst_d;
	logic [2:0]           cfg_q,        cfg_d;
	logic                 crit_q,       crit_d;
	logic [7:0]           status_q,     status_d;
	logic [7:0]           rdata_q,      rdata_d;
	logic                 rvalid_q,     rvalid_d;
	logic                 alert_q,      alert_d;
	rtl_pkg::rtl_filter_e filt_q,       filt_d;

	logic signed [10:0]   remote_s;
	logic signed [10:0]   low_s;
	logic signed [12:0]   remote_x;
	logic signed [12:0]   crit_set_x;
	logic signed [12:0]   crit_clr_x;
	logic                 cond_low;
	logic                 cond_crit;
	logic                 cond_local;
	logic [7:0]           cond_vec;
	logic                 wr_low_high;

	// ------------------------------------------------------------
	// Limit comparisons
	// ------------------------------------------------------------
	always_comb begin
		remote_s   = $signed(i_meas.remote_temp);
		low_s      = $signed({low_high_q, low_frac_q});
		cond_low   = remote_s < low_s;
		cond_local = $signed(i_meas.local_temp) > $signed(i_meas.local_high_limit);
		remote_x   = {{2{remote_s[10]}}, remote_s};
		crit_set_x = deg_to_eighths({crit_limit_q[7], crit_limit_q});
		crit_clr_x = deg_to_eighths(9'({crit_limit_q[7], crit_limit_q}
			- {crit_hyst_q[7], crit_hyst_q}));
		cond_crit  = remote_x > crit_set_x;
		crit_d     = crit_q;
		if (cond_crit) begin
			crit_d = 1'b1;
		end else if (remote_x < crit_clr_x) begin
			crit_d = 1'b0;
		end
		cond_vec = 8'h00;
		cond_vec[rtl_pkg::ST_LOCAL_HIGH]  = cond_local;
		cond_vec[rtl_pkg::ST_REMOTE_LOW]  = cond_low;
		// Alarm bit follows the plain limit; hysteresis only holds crit_q
		cond_vec[rtl_pkg::ST_REMOTE_CRIT] = cond_crit;
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		low_high_d    = low_high_q;
		low_frac_d    = low_frac_q;
		crit_limit_d  = crit_limit_q;
		crit_locked_d = crit_locked_q;
		crit_hyst_d   = crit_hyst_q;
		cfg_d         = cfg_q;
		wr_low_high   = (i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_HIGH)
			|| (i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_HIGH_B);
		if (i_reg_req.wr) begin
			// low setpoint high byte, two addresses
			if (wr_low_high) begin
				low_high_d = i_reg_req.wdata;
			end else if (i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_LOW) begin
				low_frac_d = i_reg_req.wdata[rtl_pkg::LOW_FRAC_MSB:rtl_pkg::LOW_FRAC_LSB];
			end else if (i_reg_req.addr == rtl_pkg::ADDR_CRIT_LIMIT) begin
				if (i_crit_unlock && !crit_locked_q) begin
					crit_limit_d  = i_reg_req.wdata;
					crit_locked_d = 1'b1;
				end
			end else if (i_reg_req.addr == rtl_pkg::ADDR_CRIT_HYST) begin
				crit_hyst_d = i_reg_req.wdata;
			end else if (i_reg_req.addr == rtl_pkg::ADDR_FILT_CMP_CFG) begin
				cfg_d = i_reg_req.wdata[2:0];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			low_high_q    <= rtl_pkg::RST_LOW_LIMIT_HIGH;
			low_frac_q    <= rtl_pkg::RST_LOW_LIMIT_FRAC;
			crit_limit_q  <= rtl_pkg::RST_CRIT_LIMIT;
			crit_locked_q <= 1'b0;
			crit_hyst_q   <= rtl_pkg::RST_CRIT_HYST;
			cfg_q         <= rtl_pkg::RST_FILT_CMP_CFG;
		end else begin
			low_high_q    <= low_high_d;
			low_frac_q    <= low_frac_d;
			crit_limit_q  <= crit_limit_d;
			crit_locked_q <= crit_locked_d;
			crit_hyst_q   <= crit_hyst_d;
			cfg_q         <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// Status, read data and alert
	// ------------------------------------------------------------
	always_comb begin
		// latch, clear on read only if condition gone; set wins
		status_d = cond_vec;
		if (!(i_reg_req.rd && (i_reg_req.addr == rtl_pkg::ADDR_ALARM_STATUS))) begin
			status_d = cond_vec | status_q;
		end
		rvalid_d = i_reg_req.rd;
		rdata_d  = rdata_q;
		if (i_reg_req.rd) begin
			if (i_reg_req.addr == rtl_pkg::ADDR_ALARM_STATUS) begin
				rdata_d = status_q;
				rdata_d[rtl_pkg::ST_BUSY_BIT] = i_meas.busy;
			end else if ((i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_HIGH)
				|| (i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_HIGH_B)) begin
				rdata_d = low_high_q;
			end else if (i_reg_req.addr == rtl_pkg::ADDR_LOW_LIMIT_LOW) begin
				rdata_d = {low_frac_q, 5'h00};
			end else if (i_reg_req.addr == rtl_pkg::ADDR_CRIT_LIMIT) begin
				rdata_d = crit_limit_q;
			end else if (i_reg_req.addr == rtl_pkg::ADDR_CRIT_HYST) begin
				rdata_d = crit_hyst_q;
			end else if (i_reg_req.addr == rtl_pkg::ADDR_FILT_CMP_CFG) begin
				rdata_d = {5'h00, cfg_q};
			end else begin
				rdata_d = 8'h00;
			end
		end
		// comparator follows live conditions, normal mode uses latches
		if (cfg_q[rtl_pkg::CFG_CMP_BIT]) begin
			alert_d = |cond_vec;
		end else begin
			alert_d = |status_q;
		end
		filt_d = decode_filter(cfg_q[rtl_pkg::CFG_FILT_MSB:rtl_pkg::CFG_FILT_LSB]);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			crit_q   <= 1'b0;
			status_q <= rtl_pkg::RST_STATUS;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
			alert_q  <= 1'b0;
			filt_q   <= rtl_pkg::RTL_FILT_OFF;
		end else begin
			crit_q   <= crit_d;
			status_q <= status_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			alert_q  <= alert_d;
			filt_q   <= filt_d;
		end
	end

	assign o_reg_rdata    = rdata_q;
	assign o_reg_rvalid   = rvalid_q;
	assign o_alert        = alert_q;
	assign o_filter_level = filt_q;
	assign o_crit_active  = crit_q;

endmodule

// >>> rtl_limit_alarms_chk.sv
// Checker for the remote limit and alarm block.
// Sees only the ports of rtl_limit_alarms; bound at the foot.
`timescale 1ns/1ns
module rtl_limit_alarms_chk (
	input wire logic                 i_core_clk,     // Clock
	input wire logic                 i_reset,        // Reset
	input wire rtl_pkg::rtl_req_s    i_reg_req,      // Accesses
	input wire rtl_pkg::rtl_meas_s   i_meas,         // Readings
	input wire logic                 i_crit_unlock,  // Unlock
	input wire logic [7:0]           o_reg_rdata,    // Read data
	input wire logic                 o_reg_rvalid,   // Read valid
	input wire logic                 o_alert,        // Alert
	input wire rtl_pkg::rtl_filter_e o_filter_level, // Filter
	input wire logic                 o_crit_active   // Critical
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	logic hot;
	assign hot = $signed(i_meas.local_temp) > $signed(i_meas.local_high_limit);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_rd(logic [7:0] a);
		i_reg_req.rd && i_reg_req.addr == a;
	endsequence
	sequence s_cfg(logic [1:0] c);
		i_reg_req.wr && i_reg_req.addr == 8'hBF && i_reg_req.wdata[2:1] == c;
	endsequence
	property p_rvalid; i_reg_req.rd |=> o_reg_rvalid; endproperty
	property p_quiet; !i_reg_req.rd |=> !o_reg_rvalid; endproperty
	property p_busy; s_rd(8'h02) |=> o_reg_rdata[7] == $past(i_meas.busy); endproperty
	property p_local;
		s_rd(8'h02) ##0 (hot && $past(hot) && !$past(i_reset)) |=> o_reg_rdata[6];
	endproperty
	property p_frac; s_rd(8'h14) |=> o_reg_rdata[4:0] == 5'h00; endproperty
	property p_off; s_cfg(2'b00) |=> ##1 o_filter_level == rtl_pkg::RTL_FILT_OFF; endproperty
	property p_min;
		s_cfg(2'b01) or s_cfg(2'b10) |=> ##1 o_filter_level == rtl_pkg::RTL_FILT_MIN;
	endproperty
	property p_max; s_cfg(2'b11) |=> ##1 o_filter_level == rtl_pkg::RTL_FILT_MAX; endproperty
	property p_crit; $rose(o_crit_active) |-> ##[1:2] o_alert; endproperty
	property p_reset;
		@(posedge i_core_clk) disable iff (1'b0)
		i_reset |=> !o_reg_rvalid && !o_alert && !o_crit_active;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("no read valid");
	a_quiet: assert property (p_quiet) else $error("stray read valid");
	a_busy: assert property (p_busy) else $error("busy bit wrong");
	a_local: assert property (p_local) else $error("local alarm missing");
	a_frac: assert property (p_frac) else $error("low byte bits not zero");
	a_off: assert property (p_off) else $error("filter not off");
	a_min: assert property (p_min) else $error("filter not minimal");
	a_max: assert property (p_max) else $error("filter not maximum");
	a_crit: assert property (p_crit) else $error("critical without alert");
	a_reset: assert property (p_reset) else $error("outputs not reset");
endmodule
bind rtl_limit_alarms rtl_limit_alarms_chk u_chk (.i_core_clk, .i_reset, .i_reg_req,
	.i_meas, .i_crit_unlock, .o_reg_rdata, .o_reg_rvalid, .o_alert, .o_filter_level,
	.o_crit_active);

// >>> rtl_host.sv
// Host model issuing register accesses on the strobe port.
// Assumes callers enter acc from a single process.
`timescale 1ns/1ns
module rtl_host (
	input  wire logic         i_core_clk, // Core clock
	input  wire logic [7:0]   i_rdata,    // Read data
	input  wire logic         i_rvalid,   // Read data valid
	output rtl_pkg::rtl_req_s o_req       // Access strobes
);
	initial o_req = '0;
	// ------------------------------------------------------------
	// One access, answer taken in the cycle after the strobe
	// ------------------------------------------------------------
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] r,
		output logic v);
		@(negedge i_core_clk);
		o_req.wr = w;
		o_req.rd = !w;
		o_req.addr = a;
		o_req.wdata = (a == 8'hBF) ? (d & 8'h07) : d;
		@(negedge i_core_clk);
		r = i_rdata;
		v = i_rvalid;
		o_req = {2'b00, ~a, ~d};
		@(negedge i_core_clk);
	endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the remote limit and alarm block.
// Assumes the host model drives accesses on the falling edge.
`timescale 1ns/1ns
module testbench;
	localparam logic [31:0] ROWS [12] = '{32'h40000800, 32'h40001400, 32'h40001955,
		32'h4000210A, 32'h4000BF00, 32'h08A508A5, 32'h0E3C083C, 32'h14FF14E0,
		32'h21052105, 32'hBFFFBF07, 32'h40774000, 32'h085A0E5A};
	logic clk = 0, rst = 1, unlock = 0, rvalid, alert, crit;
	logic [7:0] rdata;
	rtl_pkg::rtl_meas_s meas = {11'h190, 8'h19, 8'h46, 1'b0};
	rtl_pkg::rtl_req_s req;
	rtl_pkg::rtl_filter_e filt;
	int bad_count = 0, compares = 0;
	always #5 clk = ~clk;
	rtl_host u_host (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
	rtl_limit_alarms u_dut (.i_core_clk(clk), .i_reset(rst), .i_reg_req(req), .i_meas(meas),
		.i_crit_unlock(unlock), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_alert(alert), .o_filter_level(filt), .o_crit_active(crit));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] r;
		logic       v;
		u_host.acc(1'b1, a, d, r, v);
		chk({7'h00, v}, 8'h00);
	endtask
	task automatic rdc(input logic [7:0] a, e);
		logic [7:0] r;
		logic       v;
		u_host.acc(1'b0, a, 8'h00, r, v);
		chk({7'h00, v}, 8'h01);
		chk(r, e);
	endtask
	task automatic rem(input logic [10:0] t);
		meas.remote_temp = t;
		repeat (3) @(negedge clk);
	endtask
	task automatic final_report;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		chk({2'b00, crit, alert, rvalid, filt}, 8'h01);
		for (int i = 0; i < 12; i++) begin
			wr(ROWS[i][31:24], ROWS[i][23:16]);
			rdc(ROWS[i][15:8], ROWS[i][7:0]);
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'hBF, 8'(c << 1));
			chk({5'h00, filt}, c == 0 ? 8'h01 : c == 3 ? 8'h04 : 8'h02);
		end
		wr(8'h19, 8'h30);
		rdc(8'h19, 8'h55);
		unlock = 1'b1;
		wr(8'h19, 8'h50);
		rdc(8'h19, 8'h50);
		wr(8'h19, 8'h60);
		rdc(8'h19, 8'h50);
		wr(8'h08, 8'hF6);
		wr(8'h14, 8'h00);
		rdc(8'h02, 8'h08);
		rdc(8'h02, 8'h00);
		rem(11'h288);
		chk({7'h00, crit}, 8'h01);
		rdc(8'h02, 8'h02);
		rem(11'h258);
		chk({7'h00, crit}, 8'h01);
		rdc(8'h02, 8'h02);
		rdc(8'h02, 8'h00);
		rem(11'h257);
		chk({7'h00, crit}, 8'h00);
		rem(11'h7B0);
		rdc(8'h02, 8'h00);
		rem(11'h7AF);
		rdc(8'h02, 8'h08);
		rem(11'h190);
		chk({7'h00, alert}, 8'h01);
		rdc(8'h02, 8'h08);
		chk({7'h00, alert}, 8'h00);
		wr(8'hBF, 8'h01);
		rem(11'h7AF);
		chk({7'h00, alert}, 8'h01);
		rem(11'h190);
		chk({7'h00, alert}, 8'h00);
		rdc(8'h02, 8'h08);
		wr(8'hBF, 8'h00);
		meas.local_temp = 8'h47;
		rdc(8'h02, 8'h40);
		meas.local_temp = 8'h46;
		rdc(8'h02, 8'h40);
		rdc(8'h02, 8'h00);
		meas.busy = 1'b1;
		rdc(8'h02, 8'h80);
		chk({7'h00, alert}, 8'h00);
		meas.busy = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({2'b00, crit, alert, rvalid, filt}, 8'h01);
		rdc(8'h19, 8'h55);
		wr(8'h19, 8'h44);
		rdc(8'h19, 8'h44);
		wr(8'h19, 8'h33);
		rdc(8'h19, 8'h44);
		final_report();
	end
endmodule
